/* File: verif/passive_parallel_config_loader_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module passive_parallel_config_loader_tb;
  import ppl_pkg::*;
  localparam int FAST = 200;
  localparam int STD = 400;
  localparam int OSC = 300;
  localparam int INITC = 64;
  localparam int UNITS = 8;
  localparam int RATIO[8] = '{1, 2, 1, 2, 1, 4, 2, 4};
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic power_on_delay_select = 1'b1;
  logic bus_width_16 = 1'b0;
  logic encrypt_on = 1'b0;
  logic compress_on = 1'b0;
  logic user_init_clock = 1'b0;
  logic start = 1'b0;
  logic [DATA_W-1:0] word_data = 16'h0000;
  logic word_valid = 1'b0;
  logic word_ready;
  logic loaded;
  logic failed;
  logic user_mode;
  int fails = 0;
  int compares = 0;
  logic [15:0] seen_q[$];

  ppl_link_if u_ppl_link_if();
  ppl_device #(.FAST_POR(CNT_W'(FAST)), .STD_POR(CNT_W'(STD)), .STATUS_LOW(CNT_W'(100)),
    .OSC_INIT(CNT_W'(OSC)), .INIT_CLOCKS_MIN(CNT_W'(INITC)), .IMAGE_UNITS(UNITS)) u_ppl_device (
    .ref_clk(ref_clk), .rst_n(rst_n), .pins(u_ppl_link_if),
    .power_on_delay_select(power_on_delay_select), .bus_width_16(bus_width_16),
    .encrypt_on(encrypt_on), .compress_on(compress_on), .user_init_clock(user_init_clock),
    .user_mode(user_mode));
  ppl_host #(.REQ_TO_CLK(CNT_W'(300))) u_ppl_host (
    .ref_clk(ref_clk), .rst_n(rst_n), .pins(u_ppl_link_if), .start(start),
    .bus_width_16(bus_width_16), .encrypt_on(encrypt_on), .compress_on(compress_on),
    .word_data(word_data), .word_valid(word_valid), .word_ready(word_ready), .busy(),
    .loaded(loaded), .failed(failed));
  ppl_link_assertions #(.STATUS_LOW(100), .REQ_TO_CLK(300), .IMAGE_UNITS(UNITS),
    .INIT_MIN(INITC)) u_chk (
    .ref_clk(ref_clk), .rst_n(rst_n), .load_clock(u_ppl_link_if.load_clock),
    .config_request_n(u_ppl_link_if.config_request_n),
    .config_status_n(u_ppl_link_if.config_status_n),
    .load_complete(u_ppl_link_if.load_complete), .init_done(u_ppl_link_if.init_done));

  // clocks; user clock free-running, unrelated in phase
  always #5 ref_clk = ~ref_clk;
  always #7.5 user_init_clock = ~user_init_clock;
  // data on every rising load clock edge the device can sample
  always @(posedge u_ppl_link_if.load_clock) seen_q.push_back(u_ppl_link_if.load_data);

  task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_span(input string what, input int lo, input int hi, input int got);
    compares++;
    if (got < lo || got > hi)
    begin
      fails++;
      $display("FAIL %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  task automatic conclude;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // unit zero is the option word: init output on, user clock as asked
  function automatic logic [15:0] unit_of(input int i, input logic uclk);
    return (i == 0) ? {14'h0000, uclk, 1'b1} : 16'hA55A ^ (16'(i) * 16'h1357);
  endfunction

  task automatic t_por(input logic fast, input int lo);
    int n;
    rst_n = 1'b0;
    power_on_delay_select = fast;
    repeat (12) @(negedge ref_clk);
    rst_n = 1'b1;
    n = 0;
    while (u_ppl_link_if.config_status_n !== 1'b1 && n < 4 * lo)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk_span("power-on delay", lo, 3 * lo + 10, n);
    chk_val("done after power-up", 16'h0000, {15'h0000, u_ppl_link_if.load_complete});
    $display("test power-on select %0b done", fast);
  endtask

  task automatic t_load(input logic w16, input logic enc, input logic comp, input int r,
                        input logic uclk);
    int n;
    int i;
    logic [15:0] u;
    bus_width_16 = w16;
    encrypt_on = enc;
    compress_on = comp;
    seen_q.delete();
    start = 1'b1;
    @(negedge ref_clk);
    start = 1'b0;
    // 595 ns after the request falls
    repeat (59) @(negedge ref_clk);
    chk_val("lines after request", 16'h0000, {13'h0000, u_ppl_link_if.config_status_n,
      u_ppl_link_if.load_complete, user_mode});
    i = 0;
    n = 0;
    word_data = unit_of(0, uclk);
    word_valid = 1'b1;
    while (i < UNITS && n < 20000)
    begin
      @(negedge ref_clk);
      n++;
      if (word_ready === 1'b1)
      begin
        @(negedge ref_clk);
        i++;
        word_data = unit_of(i, uclk);
      end
    end
    word_valid = 1'b0;
    n = 0;
    while (u_ppl_link_if.load_complete !== 1'b1 && n < 20000)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk_span("rises at done", UNITS * r, UNITS * r, seen_q.size());
    repeat (4) @(negedge ref_clk);
    chk_val("init output", 16'h0000, {15'h0000, u_ppl_link_if.init_done});
    n = 0;
    while (user_mode !== 1'b1 && n < 20000)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk_span("init time", uclk ? INITC * 3 / 2 - 4 : OSC - 4, uclk ? 2000 : 749, n);
    chk_span("rises total", UNITS * r + 2, UNITS * r + 2, seen_q.size());
    chk_val("user lines", 16'h000D, {12'h000, u_ppl_link_if.config_status_n,
      u_ppl_link_if.load_complete, failed, u_ppl_link_if.init_done & loaded});
    // each unit stands for r rising edges on the used lines
    for (i = 0; i < UNITS * r; i++)
    begin
      u = unit_of(i / r, uclk);
      chk_val("unit on data", w16 ? u : {8'h00, u[7:0]}, seen_q[i]);
    end
    $display("test load width16 %0b enc %0b comp %0b done", w16, enc, comp);
  endtask

  initial
  begin
    t_por(1'b0, STD);
    t_por(1'b1, FAST);
    // every width, encryption and compression setting
    for (int k = 0; k < 8; k++)
      t_load(k[2], k[1], k[0], RATIO[k], k == 7);
    conclude();
  end

  // bound on the whole run, well above the expected length
  initial
  begin
    #400000;
    fails++;
    $display("FAIL watchdog expected finish seen hang");
    conclude();
  end
endmodule
`default_nettype wire

/* File: verif/ppl_link_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module ppl_link_assertions #(
  parameter int STATUS_LOW = 100,
  parameter int REQ_TO_CLK = 300,
  parameter int IMAGE_UNITS = 8,
  parameter int INIT_MIN = 64
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic load_clock,
  input wire logic config_request_n,
  input wire logic config_status_n,
  input wire logic load_complete,
  input wire logic init_done
);
  localparam int DROP_MAX = 60;
  localparam int REL_MAX = 1000;
  localparam int GAP_MIN = 200;
  int st_low;
  int st_high;
  int req_low;
  int req_high;
  int init_low;
  int rises;
  logic clk_q;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // run lengths per line level; link clock is slow enough to sample here
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_low <= 0;
      st_high <= 0;
      req_low <= 0;
      req_high <= 0;
      init_low <= 0;
      rises <= 0;
      clk_q <= 1'b0;
    end
    else
    begin
      st_low <= config_status_n ? 0 : st_low + 1;
      st_high <= config_status_n ? st_high + 1 : 0;
      req_low <= config_request_n ? 0 : req_low + 1;
      req_high <= config_request_n ? req_high + 1 : 0;
      init_low <= init_done ? 0 : init_low + 1;
      rises <= !config_request_n ? 0 : rises + int'(load_clock && !clk_q);
      clk_q <= load_clock;
    end
  end

  chk_req_drops_lines: assert property (
    $fell(config_request_n) |-> ##[1:DROP_MAX] (!load_complete && !config_status_n))
    else $error("done or status not low after request");
  chk_status_pulse_min: assert property (
    $rose(config_status_n) |-> st_low >= STATUS_LOW)
    else $error("status pulse too short");
  chk_status_release: assert property (
    $rose(config_request_n) |-> ##[1:REL_MAX] config_status_n)
    else $error("status not released after request");
  chk_done_after_image: assert property (
    $rose(load_complete) |-> rises >= IMAGE_UNITS)
    else $error("done before whole image");
  chk_done_holds_high: assert property (
    load_complete && config_request_n |=> load_complete)
    else $error("done dropped without request");
  chk_init_from_done: assert property (
    $fell(init_done) |-> load_complete)
    else $error("init output low before done");
  chk_init_clock_count: assert property (
    $rose(init_done) |-> init_low >= INIT_MIN)
    else $error("initialization too short");
  chk_req_low_width: assert property (
    $rose(config_request_n) |-> req_low >= GAP_MIN)
    else $error("request pulse too short");
  chk_first_clock_wait: assert property (
    $rose(load_clock) && rises == 0 |-> req_high >= REQ_TO_CLK && st_high >= GAP_MIN)
    else $error("first load clock too early");

  cover property ($rose(load_complete));
  cover property ($rose(init_done));
  cover property ($fell(config_request_n) && load_complete);
endmodule
`default_nettype wire

/* File: verilog/ppl_device.sv */
`timescale 1ns/10ps
`default_nettype none
module ppl_device
  import ppl_pkg::*;
#(
  parameter logic [CNT_W-1:0] FAST_POR = CNT_W'(FAST_POR_CYCLES),
  parameter logic [CNT_W-1:0] STD_POR = CNT_W'(STD_POR_CYCLES),
  parameter logic [CNT_W-1:0] STATUS_LOW = CNT_W'(STATUS_LOW_CYCLES),
  parameter logic [CNT_W-1:0] OSC_INIT = CNT_W'(OSC_INIT_CYCLES),
  parameter logic [CNT_W-1:0] INIT_CLOCKS_MIN = CNT_W'(INIT_CLOCKS),
  parameter int IMAGE_UNITS = IMAGE_WORDS
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  ppl_link_if.device pins,
  input wire logic power_on_delay_select,
  input wire logic bus_width_16,
  input wire logic encrypt_on,
  input wire logic compress_on,
  input wire logic user_init_clock,
  output logic user_mode
);
  localparam int UNIT_W = $clog2(IMAGE_UNITS + 1);

  typedef enum logic [2:0] {
    ST_POR = 3'h0,
    ST_PULSE = 3'h1,
    ST_LOAD = 3'h3,
    ST_DONE = 3'h2,
    ST_CLK_WAIT = 3'h6,
    ST_INIT = 3'h7,
    ST_USER = 3'h5
  } dev_state_type;

  typedef struct packed {
    dev_state_type state;
    logic [CNT_W-1:0] count;
    logic [1:0] req_sync;
    logic [1:0] stat_sync;
    logic [1:0] sel_sync;
    logic [2:0] uclk_sync;
    logic [2:0] mode_meta;
    logic [2:0] mode_sync;
    logic [2:0] rx_meta;
    logic [2:0] rx_sync;
    logic [1:0] fall_sync;
    logic [2:0] ratio;
    logic wide;
    logic run;
    logic use_user_clk;
    logic pin_low;
    logic status_oe_n;
    logic done_oe_n;
    logic init_oe_n;
    logic user_mode;
  } ctrl_type;

  typedef struct packed {
    logic [2:0] phase;
    logic [UNIT_W-1:0] units;
    logic received;
    logic opt_user;
    logic opt_init;
  } link_type;

  localparam ctrl_type CTRL_RESET = '{state: ST_POR, init_oe_n: 1'b1, default: '0};

  ctrl_type ctrl;
  ctrl_type next_ctrl;
  link_type link;
  link_type next_link;
  logic [DATA_W-1:0] unit_data;
  logic [1:0] falls;
  logic link_rst_n;
  logic uclk_edge;

  // common entry into loading; mode straps are frozen here
  function automatic ctrl_type enter_load(input ctrl_type c);
    ctrl_type e;
    e = c;
    e.state = ST_LOAD;
    e.count = '0;
    e.status_oe_n = 1'b1;
    e.ratio = clock_ratio(c.mode_sync[2], c.mode_sync[1], c.mode_sync[0]);
    e.wide = c.mode_sync[2];
    return e;
  endfunction

  // link side held in reset outside a load; released >= 2 us before first edge
  assign link_rst_n = rst_n & ctrl.run;
  assign uclk_edge = ctrl.uclk_sync[1] & ~ctrl.uclk_sync[2];

  // control side on the internal oscillator
  always_comb
  begin
    next_ctrl = ctrl;
    next_ctrl.req_sync = {ctrl.req_sync[0], pins.config_request_n};
    next_ctrl.stat_sync = {ctrl.stat_sync[0], pins.config_status_n};
    next_ctrl.sel_sync = {ctrl.sel_sync[0], power_on_delay_select};
    next_ctrl.uclk_sync = {ctrl.uclk_sync[1:0], user_init_clock};
    next_ctrl.mode_meta = {bus_width_16, encrypt_on, compress_on};
    next_ctrl.mode_sync = ctrl.mode_meta;
    // option bits settle at unit zero, long before received rises
    next_ctrl.rx_meta = {link.received, link.opt_user, link.opt_init};
    next_ctrl.rx_sync = ctrl.rx_meta;
    next_ctrl.fall_sync = {ctrl.fall_sync[0], &falls};
    // saturating so long waits never wrap
    if (ctrl.count != '1)
      next_ctrl.count = ctrl.count + 1'b1;
    case (ctrl.state)
      ST_POR:
      begin
        // status stays low until the end
        if (ctrl.count >= (ctrl.sel_sync[1] ? FAST_POR : STD_POR))
          next_ctrl = enter_load(next_ctrl);
      end
      ST_PULSE:
      begin
        if (ctrl.count >= STATUS_LOW)
          next_ctrl = enter_load(next_ctrl);
      end
      ST_LOAD:
      begin
        // an externally held status line keeps the link idle
        if (ctrl.stat_sync[1])
          next_ctrl.run = 1'b1;
        // done only after the last unit
        if (ctrl.rx_sync[2])
        begin
          next_ctrl.state = ST_DONE;
          next_ctrl.done_oe_n = 1'b1;
          next_ctrl.use_user_clk = ctrl.rx_sync[1];
          next_ctrl.init_oe_n = ~ctrl.rx_sync[0];
        end
      end
      ST_DONE:
      begin
        if (ctrl.fall_sync[1])
        begin
          next_ctrl.state = ST_CLK_WAIT;
          next_ctrl.run = 1'b0;
          next_ctrl.count = '0;
        end
      end
      ST_CLK_WAIT:
      begin
        if (!ctrl.use_user_clk || ctrl.count >= CNT_W'(USER_CLK_WAIT_CYCLES))
        begin
          next_ctrl.state = ST_INIT;
          next_ctrl.count = '0;
        end
      end
      ST_INIT:
      begin
        if (ctrl.use_user_clk)
          next_ctrl.count = ctrl.count + {{(CNT_W-1){1'b0}}, uclk_edge};
        if (next_ctrl.count >= (ctrl.use_user_clk ? INIT_CLOCKS_MIN : OSC_INIT))
        begin
          next_ctrl.state = ST_USER;
          next_ctrl.init_oe_n = 1'b1;
          next_ctrl.user_mode = 1'b1;
        end
      end
      ST_USER:
      begin
        next_ctrl.count = ctrl.count;
      end
      default:
      begin
        next_ctrl.state = ST_POR;
        next_ctrl.count = '0;
      end
    endcase
    // request low restarts from any state after power-on
    // done and status drop within a few cycles
    if (!ctrl.req_sync[1] && ctrl.state != ST_POR)
    begin
      next_ctrl.state = ST_PULSE;
      next_ctrl.count = '0;
      next_ctrl.status_oe_n = 1'b0;
      next_ctrl.done_oe_n = 1'b0;
      next_ctrl.init_oe_n = 1'b1;
      next_ctrl.run = 1'b0;
      next_ctrl.user_mode = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl <= CTRL_RESET;
    else
      ctrl <= next_ctrl;
  end

  // done low from reset onward via CTRL_RESET
  assign pins.status_out = ctrl.pin_low;
  assign pins.status_oe_n = ctrl.status_oe_n;
  assign pins.done_out = ctrl.pin_low;
  assign pins.done_oe_n = ctrl.done_oe_n;
  assign pins.init_out = ctrl.pin_low;
  assign pins.init_oe_n = ctrl.init_oe_n;
  // data lines free for user logic from here
  assign user_mode = ctrl.user_mode;

  // unit assembly on the load clock; ratio and width static during a load
  always_comb
  begin
    next_link = link;
    // narrow mode ignores the upper lines
    unit_data = ctrl.wide ? pins.load_data : {{BYTE_W{1'b0}}, pins.load_data[BYTE_W-1:0]};
    if (!link.received)
    begin
      next_link.phase = link.phase + 3'h1;
      // one unit per r rising edges
      if (link.phase == ctrl.ratio - 3'h1)
      begin
        next_link.phase = 3'h0;
        next_link.units = link.units + 1'b1;
        if (link.units == '0)
        begin
          next_link.opt_init = unit_data[OPT_INIT_DONE_BIT];
          next_link.opt_user = unit_data[OPT_USER_CLK_BIT];
        end
        if (link.units == UNIT_W'(IMAGE_UNITS - 1))
          next_link.received = 1'b1;
      end
    end
  end

  // data taken on the rising edge
  always_ff @(posedge pins.load_clock or negedge link_rst_n)
  begin
    if (!link_rst_n)
      link <= '0;
    else
      link <= next_link;
  end

  // falls after the last unit start initialization
  always_ff @(negedge pins.load_clock or negedge link_rst_n)
  begin
    if (!link_rst_n)
      falls <= 2'h0;
    else if (link.received && falls != FALLS_TO_INIT)
      falls <= falls + 2'h1;
  end
endmodule
`default_nettype wire

/* File: verilog/ppl_host.sv */
`timescale 1ns/10ps
`default_nettype none
module ppl_host
  import ppl_pkg::*;
#(
  parameter logic [CNT_W-1:0] REQ_TO_CLK = CNT_W'(REQ_HIGH_TO_CLK_CYCLES)
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  ppl_link_if.host pins,
  input wire logic start,
  input wire logic bus_width_16,
  input wire logic encrypt_on,
  input wire logic compress_on,
  input wire logic [DATA_W-1:0] word_data,
  input wire logic word_valid,
  output logic word_ready,
  output logic busy,
  output logic loaded,
  output logic failed
);
  typedef enum logic [2:0] {
    HS_IDLE = 3'h0,
    HS_REQ = 3'h1,
    HS_WAIT = 3'h3,
    HS_GAP = 3'h2,
    HS_SEND = 3'h6,
    HS_EXTRA = 3'h7
  } host_state_type;

  typedef struct packed {
    host_state_type state;
    logic [CNT_W-1:0] count;
    logic [1:0] stat_sync;
    logic [1:0] done_sync;
    logic clk;
    logic req_n;
    logic [DATA_W-1:0] data;
    logic have;
    logic [2:0] rises;
    logic [2:0] ratio;
    logic wide;
    logic falls;
    logic ready;
    logic busy;
    logic loaded;
    logic failed;
  } host_type;

  localparam host_type HOST_RESET = '{state: HS_IDLE, req_n: 1'b1, default: '0};

  host_type host;
  host_type next_host;

  always_comb
  begin
    next_host = host;
    next_host.stat_sync = {host.stat_sync[0], pins.config_status_n};
    next_host.done_sync = {host.done_sync[0], pins.load_complete};
    if (host.count != '1)
      next_host.count = host.count + 1'b1;
    case (host.state)
      HS_IDLE:
      begin
        if (start)
        begin
          next_host.state = HS_REQ;
          next_host.req_n = 1'b0;
          next_host.count = '0;
          next_host.busy = 1'b1;
          next_host.loaded = 1'b0;
          next_host.failed = 1'b0;
          // clock ratio chosen for this load
          next_host.ratio = clock_ratio(bus_width_16, encrypt_on, compress_on);
          next_host.wide = bus_width_16;
        end
      end
      HS_REQ:
      begin
        // request low for the least pulse
        if (host.count >= CNT_W'(REQ_LOW_CYCLES - 1))
        begin
          next_host.state = HS_WAIT;
          next_host.req_n = 1'b1;
          next_host.count = '0;
        end
      end
      HS_WAIT:
      begin
        if (host.count >= REQ_TO_CLK && host.stat_sync[1])
        begin
          next_host.state = HS_GAP;
          next_host.count = '0;
        end
      end
      HS_GAP:
      begin
        if (!host.stat_sync[1])
          next_host.state = HS_WAIT;
        else if (host.count >= CNT_W'(STATUS_HIGH_TO_CLK_CYCLES))
        begin
          next_host.state = HS_SEND;
          next_host.ready = 1'b1;
        end
      end
      HS_SEND:
      begin
        if (!host.stat_sync[1])
        begin
          // device flagged an error mid-stream
          next_host.state = HS_IDLE;
          next_host.failed = 1'b1;
          next_host.busy = 1'b0;
          next_host.ready = 1'b0;
          next_host.have = 1'b0;
          next_host.clk = 1'b0;
        end
        else if (host.done_sync[1] && !host.clk)
        begin
          next_host.state = HS_EXTRA;
          next_host.ready = 1'b0;
          next_host.falls = 1'b0;
        end
        else
        begin
          // half period of one ref cycle, well under the limit
          if (host.clk)
            next_host.clk = 1'b0;
          else if (host.have)
          begin
            next_host.clk = 1'b1;
            // unit stays for r rising edges
            if (host.rises == host.ratio - 3'h1)
            begin
              next_host.rises = 3'h0;
              next_host.have = 1'b0;
              next_host.ready = 1'b1;
            end
            else
              next_host.rises = host.rises + 3'h1;
          end
          // clock paused low while the source has nothing
          if (word_valid && host.ready)
          begin
            // narrow mode drives only the low lines
            next_host.data = host.wide ? word_data
                                       : {{BYTE_W{1'b0}}, word_data[BYTE_W-1:0]};
            next_host.have = 1'b1;
            next_host.ready = 1'b0;
          end
        end
      end
      HS_EXTRA:
      begin
        if (host.clk)
        begin
          next_host.clk = 1'b0;
          next_host.falls = 1'b1;
          if (host.falls)
          begin
            next_host.state = HS_IDLE;
            next_host.busy = 1'b0;
            next_host.loaded = 1'b1;
          end
        end
        else
          next_host.clk = 1'b1;
      end
      default:
      begin
        next_host.state = HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      host <= HOST_RESET;
    else
      host <= next_host;
  end

  // load clock derived from ref_clk; left low between loads
  assign pins.load_clock = host.clk;
  assign pins.config_request_n = host.req_n;
  assign pins.load_data = host.data;
  assign word_ready = host.ready;
  assign busy = host.busy;
  assign loaded = host.loaded;
  assign failed = host.failed;
endmodule
`default_nettype wire

/* File: verilog/ppl_link_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface ppl_link_if;
  logic load_clock;
  logic config_request_n;
  logic [15:0] load_data;
  logic status_out;
  logic status_oe_n;
  logic done_out;
  logic done_oe_n;
  logic init_out;
  logic init_oe_n;
  logic config_status_n;
  logic load_complete;
  logic init_done;

  // open-drain lines with pull-ups: high unless driven low
  assign config_status_n = status_oe_n | status_out;
  assign load_complete = done_oe_n | done_out;
  assign init_done = init_oe_n | init_out;

  modport device(
    input load_clock, config_request_n, load_data, config_status_n,
    output status_out, status_oe_n, done_out, done_oe_n, init_out, init_oe_n
  );
  modport host(
    output load_clock, config_request_n, load_data,
    input config_status_n, load_complete, init_done
  );
endinterface
`default_nettype wire

/* File: verilog/ppl_pkg.sv */
`default_nettype none
package ppl_pkg;
  localparam int REF_CLK_MHZ = 100;
  localparam int CNT_W = 24;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  // power-on delay: least value of each range, so the device is ready early
  localparam int FAST_POR_MIN_MS = 4;
  localparam int STD_POR_MIN_MS = 100;
  localparam int FAST_POR_CYCLES = FAST_POR_MIN_MS * 1000 * REF_CLK_MHZ;
  localparam int STD_POR_CYCLES = STD_POR_MIN_MS * 1000 * REF_CLK_MHZ;
  // reconfiguration pulse on the status line
  localparam int STATUS_LOW_MIN_US = 268;
  localparam int STATUS_LOW_CYCLES = STATUS_LOW_MIN_US * REF_CLK_MHZ;
  // initialization from the internal oscillator or from the user clock
  localparam int OSC_INIT_MIN_US = 175;
  localparam int OSC_INIT_CYCLES = OSC_INIT_MIN_US * REF_CLK_MHZ;
  localparam int INIT_CLOCKS = 17408;
  // user clock enable waits four of the shortest load clock periods
  localparam int LOAD_CLK_MAX_MHZ = 125;
  localparam int LOAD_CLK_MIN_PERIOD_NS = 1000 / LOAD_CLK_MAX_MHZ;
  localparam int USER_CLK_WAIT_PERIODS = 4;
  localparam int USER_CLK_WAIT_CYCLES =
    (USER_CLK_WAIT_PERIODS * LOAD_CLK_MIN_PERIOD_NS * REF_CLK_MHZ + 999) / 1000;
  // host side timing
  localparam int REQ_LOW_MIN_US = 2;
  localparam int REQ_LOW_CYCLES = REQ_LOW_MIN_US * REF_CLK_MHZ;
  localparam int REQ_HIGH_TO_CLK_MIN_US = 1506;
  localparam int REQ_HIGH_TO_CLK_CYCLES = REQ_HIGH_TO_CLK_MIN_US * REF_CLK_MHZ;
  localparam int STATUS_HIGH_TO_CLK_MIN_US = 2;
  localparam int STATUS_HIGH_TO_CLK_CYCLES = STATUS_HIGH_TO_CLK_MIN_US * REF_CLK_MHZ;
  // falls counted after the last unit: one trailing plus two extra
  localparam logic [1:0] FALLS_TO_INIT = 2'h3;
  // option word: first unit of the stream
  localparam int OPT_INIT_DONE_BIT = 0;
  localparam int OPT_USER_CLK_BIT = 1;
  localparam int IMAGE_WORDS = 64;
  localparam logic [2:0] RATIO_ONE = 3'h1;
  localparam logic [2:0] RATIO_TWO = 3'h2;
  localparam logic [2:0] RATIO_FOUR = 3'h4;

  // load clock edges per data unit
  function automatic logic [2:0] clock_ratio(input logic wide, input logic encrypt,
                                             input logic compress);
    logic [2:0] ratio;
    ratio = RATIO_ONE;
    if (compress)
      ratio = wide ? RATIO_FOUR : RATIO_TWO;
    else if (encrypt && wide)
      ratio = RATIO_TWO;
    return ratio;
  endfunction
endpackage
`default_nettype wire
